// ===== common/ccpu_regs.svh
// Register indices, field positions and reset values of the capture/compare/PWM pair.
// Assumes APB byte address = 4 * index.
`ifndef CCPU_REGS_SVH
`define CCPU_REGS_SVH
`define CCPU_IDX_U1_LOW 6'h15
`define CCPU_IDX_U1_HIGH 6'h16
`define CCPU_IDX_U1_CTRL 6'h17
`define CCPU_IDX_U2_LOW 6'h1B
`define CCPU_IDX_U2_HIGH 6'h1C
`define CCPU_IDX_U2_CTRL 6'h1D
`define CCPU_IDX_FLAGS 6'h20
`define CCPU_CTRL_MODE_LSB 0
`define CCPU_CTRL_DUTY_LSB 4
`define CCPU_CTRL_RESET 6'h00
`define CCPU_PS4_LAST 4'h3
`define CCPU_PS16_LAST 4'hF
`endif

// ===== common/ccpu_pkg.sv
// Types shared by the capture/compare/PWM pair.
// Assumes ccpu_regs.svh for numeric constants.
`default_nettype none
package ccpu_pkg;
    typedef logic [3:0] ccpu_mode_t;
    typedef enum logic [3:0] {
        KIND_OFF = 4'b0001,
        KIND_CAP = 4'b0010,
        KIND_CMP = 4'b0100,
        KIND_PWM = 4'b1000
    } ccpu_kind_e;

    function automatic ccpu_kind_e ccpu_kind(input ccpu_mode_t m);
        if (m[3:2] == 2'b11) begin
            return KIND_PWM;
        end else if (m[3]) begin
            return KIND_CMP;
        end else if (m[2]) begin
            return KIND_CAP;
        end
        // Codes 0000-0011 are treated as off
        return KIND_OFF;
    endfunction : ccpu_kind
endpackage : ccpu_pkg
`default_nettype wire

// ===== hdl/ccpu_unit.sv
// Two capture/compare/PWM units with an APB register slave.
// Assumes timer counts arrive on pclk; the unit pins come from outside and are synchronised.
//
// The implementer's own choice: the APB slave port.
`include "ccpu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ccpu_unit
    import ccpu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] unit_pin_in,
    input wire logic [15:0] timer_one_count,
    input wire logic [7:0] timer_two_count,
    input wire logic [7:0] timer_two_period,
    input wire logic [1:0] timer_two_frac,
    input wire logic timer_two_inc,
    input wire logic adc_enable,
    output logic [1:0] unit_pin_out,
    output logic [1:0] unit_event_flag,
    output logic timer_one_reset,
    output logic adc_start
);

    logic [5:0] ctrl_r [2];
    logic [7:0] low_r [2];
    logic [7:0] high_r [2];
    logic [1:0] duty_lat_r [2];
    logic [3:0] pscnt_r [2];
    logic [1:0] flag_r;
    logic [1:0] pin_out_r;
    logic [1:0] match_prev_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic timer_one_count_rst_r;
    logic adc_start_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // APB decode; one wait state so every answer comes from a flop
    logic [5:0] idx;
    logic setup_acc;
    logic wr_en;
    logic [1:0] sel_low;
    logic [1:0] sel_high;
    logic [1:0] sel_ctrl;
    logic sel_flags;
    logic mapped;
    logic [31:0] rd_mux;

    assign idx = paddr[7:2];
    assign setup_acc = psel && penable && !pready_r;
    assign wr_en = psel && penable && pready_r && pwrite && mapped;
    assign sel_low[0] = (idx == `CCPU_IDX_U1_LOW);
    assign sel_low[1] = (idx == `CCPU_IDX_U2_LOW);
    assign sel_high[0] = (idx == `CCPU_IDX_U1_HIGH);
    assign sel_high[1] = (idx == `CCPU_IDX_U2_HIGH);
    assign sel_ctrl[0] = (idx == `CCPU_IDX_U1_CTRL);
    assign sel_ctrl[1] = (idx == `CCPU_IDX_U2_CTRL);
    assign sel_flags = (idx == `CCPU_IDX_FLAGS);
    assign mapped = (|sel_low) || (|sel_high) || (|sel_ctrl) || sel_flags;
    assign rd_mux = sel_low[0] ? {24'h000000, low_r[0]} :
                    sel_low[1] ? {24'h000000, low_r[1]} :
                    sel_high[0] ? {24'h000000, high_r[0]} :
                    sel_high[1] ? {24'h000000, high_r[1]} :
                    sel_ctrl[0] ? {26'h0000000, ctrl_r[0]} :
                    sel_ctrl[1] ? {26'h0000000, ctrl_r[1]} :
                    sel_flags ? {30'h00000000, flag_r} : 32'h00000000;

    // Per-unit decode of mode and events
    ccpu_kind_e kind [2];
    ccpu_mode_t mode [2];
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] cap_ev;
    logic [1:0] eq;
    logic [1:0] cmp_ev;
    logic [1:0] trig_ev;
    logic [1:0] pwm_set;
    logic [1:0] pwm_clr;
    logic [1:0] flag_clr;
    logic wrap;

    // Period end is seen on the increment after timer two equals its period
    assign wrap = timer_two_inc && (timer_two_count == timer_two_period);

    for (genvar u = 0; u < 2; u++) begin : g_dec
        assign mode[u] = ctrl_r[u][3:0];
        assign kind[u] = ccpu_kind(mode[u]);
        // Third stage is the edge reference; first stage is read only by the second
        assign rise[u] = sync2_r[u] && !sync3_r[u];
        assign fall[u] = !sync2_r[u] && sync3_r[u];
        assign cap_ev[u] = (kind[u] == KIND_CAP) && (
            (mode[u][1:0] == 2'b00 && fall[u]) ||
            (mode[u][1:0] == 2'b01 && rise[u]) ||
            (mode[u][1:0] == 2'b10 && rise[u] && pscnt_r[u] == `CCPU_PS4_LAST) ||
            (mode[u][1:0] == 2'b11 && rise[u] && pscnt_r[u] == `CCPU_PS16_LAST));
        assign eq[u] = ({high_r[u], low_r[u]} == timer_one_count);
        // Act once per arrival at equality, not every cycle the count rests there
        assign cmp_ev[u] = (kind[u] == KIND_CMP) && eq[u] && !match_prev_r[u];
        assign trig_ev[u] = cmp_ev[u] && (mode[u][1:0] == 2'b11);
        assign pwm_set[u] = (kind[u] == KIND_PWM) && wrap;
        assign pwm_clr[u] = (kind[u] == KIND_PWM) &&
            ({high_r[u], duty_lat_r[u]} == {timer_two_count, timer_two_frac});
        assign flag_clr[u] = wr_en && sel_flags && pwdata[u];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 2'b00;
            sync2_r <= 2'b00;
            sync3_r <= 2'b00;
        end else begin
            sync1_r <= unit_pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= setup_acc;
            pslverr_r <= setup_acc && !mapped;
            prdata_r <= (setup_acc && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    for (genvar u = 0; u < 2; u++) begin : g_unit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl_r[u] <= `CCPU_CTRL_RESET;
            end else if (wr_en && sel_ctrl[u]) begin
                ctrl_r[u] <= pwdata[5:0];
            end
        end

        // Prescaler keeps counting across a direct change between capture codes
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pscnt_r[u] <= 4'h0;
            end else if (kind[u] != KIND_CAP) begin
                pscnt_r[u] <= 4'h0;
            end else if (rise[u] && cap_ev[u]) begin
                // Restart after the counted edge, else 4th-edge code would wait sixteen
                pscnt_r[u] <= 4'h0;
            end else if (rise[u]) begin
                pscnt_r[u] <= pscnt_r[u] + 4'h1;
            end
        end

        // Capture wins over a software write in the same cycle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                low_r[u] <= 8'h00;
                high_r[u] <= 8'h00;
            end else if (cap_ev[u]) begin
                low_r[u] <= timer_one_count[7:0];
                high_r[u] <= timer_one_count[15:8];
            end else begin
                if (wr_en && sel_low[u]) begin
                    low_r[u] <= pwdata[7:0];
                end
                if (pwm_set[u]) begin
                    high_r[u] <= low_r[u];
                end else if (wr_en && sel_high[u] && kind[u] != KIND_PWM) begin
                    high_r[u] <= pwdata[7:0];
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                duty_lat_r[u] <= 2'b00;
            end else if (kind[u] != KIND_PWM) begin
                duty_lat_r[u] <= 2'b00;
            end else if (pwm_set[u]) begin
                duty_lat_r[u] <= ctrl_r[u][`CCPU_CTRL_DUTY_LSB +: 2];
            end
        end

        // Set by an event wins over a software clear in the same cycle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_r[u] <= 1'b0;
            end else if (cap_ev[u] || cmp_ev[u]) begin
                flag_r[u] <= 1'b1;
            end else if (flag_clr[u]) begin
                flag_r[u] <= 1'b0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                match_prev_r[u] <= 1'b0;
            end else begin
                match_prev_r[u] <= eq[u] && (kind[u] == KIND_CMP);
            end
        end

        // Output latch is separate from any port data latch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_out_r[u] <= 1'b0;
            end else if (kind[u] == KIND_OFF) begin
                pin_out_r[u] <= 1'b0;
            end else if (cmp_ev[u] && mode[u][1:0] == 2'b00) begin
                pin_out_r[u] <= 1'b1;
            end else if (cmp_ev[u] && mode[u][1:0] == 2'b01) begin
                pin_out_r[u] <= 1'b0;
            end else if (pwm_set[u]) begin
                pin_out_r[u] <= ({low_r[u], ctrl_r[u][5:4]} != 10'h000);
            end else if (pwm_clr[u]) begin
                pin_out_r[u] <= 1'b0;
            end
        end
    end

    // Trigger clear is its own path, never the overflow path of timer one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_count_rst_r <= 1'b0;
            adc_start_r <= 1'b0;
        end else begin
            timer_one_count_rst_r <= |trig_ev;
            adc_start_r <= trig_ev[1] && adc_enable;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign unit_pin_out = pin_out_r;
    assign unit_event_flag = flag_r;
    assign timer_one_reset = timer_one_count_rst_r;
    assign adc_start = adc_start_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    for (genvar g = 0; g < 2; g++) begin : g_chk
        off_state_a: assert property ((kind[g] == KIND_OFF) |=>
            (!pin_out_r[g] && pscnt_r[g] == 4'h0))
            else $error("Unit off but state not cleared");
        cap_copy_a: assert property (cap_ev[g] |=>
            ({high_r[g], low_r[g]} == $past(timer_one_count)))
            else $error("Capture did not copy timer one");
        flag_hold_a: assert property ((flag_r[g] && !flag_clr[g]) |=> flag_r[g])
            else $error("Event flag dropped without clear");
        cap_flag_a: assert property (cap_ev[g] |=> flag_r[g])
            else $error("Capture did not set flag");
        cmp_high_a: assert property ((cmp_ev[g] && mode[g] == 4'h8) |=> pin_out_r[g])
            else $error("Compare set mode did not drive high");
        cmp_low_a: assert property ((cmp_ev[g] && mode[g] == 4'h9) |=> !pin_out_r[g])
            else $error("Compare clear mode did not drive low");
        swi_pin_a: assert property ((cmp_ev[g] && mode[g] == 4'hA) |=>
            $stable(pin_out_r[g]))
            else $error("Software compare touched pin");
        pwm_start_a: assert property ((pwm_set[g] && {low_r[g], ctrl_r[g][5:4]} != 10'h000)
            |=> (pin_out_r[g] && high_r[g] == $past(low_r[g])))
            else $error("Period start missed set or load");
        high_ro_a: assert property ((kind[g] == KIND_PWM && !pwm_set[g]) |=>
            $stable(high_r[g]) || kind[g] != KIND_PWM)
            else $error("High byte changed in PWM");

        // Capture path and prescaler
        psc_idle_a: assert property ((kind[g] != KIND_CAP) |=> pscnt_r[g] == 4'h0)
            else $error("Prescaler not cleared outside capture");
        psc_keep_a: assert property ((kind[g] == KIND_CAP && !rise[g]) |=>
            $stable(pscnt_r[g]))
            else $error("Prescaler moved without a rising edge");
        edge_pulse_a: assert property (rise[g] |=> !rise[g])
            else $error("Pin edge lasted more than one cycle");
        flag_clear_a: assert property (
            (flag_clr[g] && !cap_ev[g] && !cmp_ev[g]) |=> !flag_r[g])
            else $error("Software clear did not clear flag");
        ctrl_write_a: assert property ((wr_en && sel_ctrl[g]) |=>
            ctrl_r[g] == $past(pwdata[5:0]))
            else $error("Control write did not land");

        // Compare path
        cmp_flag_a: assert property (cmp_ev[g] |=> flag_r[g])
            else $error("Compare match did not set flag");
        cmp_once_a: assert property (cmp_ev[g] |=> !cmp_ev[g])
            else $error("Compare fired twice on one arrival");
        cmp_hold_a: assert property ((kind[g] == KIND_CMP && !wr_en) |=>
            $stable({high_r[g], low_r[g]}))
            else $error("Compare register changed without a write");

        // Pulse-width path
        pwm_zero_a: assert property (
            (pwm_set[g] && {low_r[g], ctrl_r[g][5:4]} == 10'h000) |=> !pin_out_r[g])
            else $error("Zero duty still set the pin");
        pwm_clear_a: assert property (
            (kind[g] == KIND_PWM && pwm_clr[g] && !pwm_set[g]) |=> !pin_out_r[g])
            else $error("Duty match did not clear the pin");
        pwm_rise_a: assert property ((kind[g] == KIND_PWM && !pwm_set[g]) |=>
            !$rose(pin_out_r[g]))
            else $error("Pin rose away from period start");
        pwm_load_a: assert property (pwm_set[g] |=>
            duty_lat_r[g] == $past(ctrl_r[g][5:4]))
            else $error("Duty low bits not latched at period start");
        duty_idle_a: assert property ((kind[g] != KIND_PWM) |=>
            duty_lat_r[g] == 2'b00)
            else $error("Duty latch kept outside pulse-width mode");
    end

    trig_pulse_a: assert property (|trig_ev |=> timer_one_reset ##1 (!timer_one_reset ||
        $past(|trig_ev)))
        else $error("Trigger reset not a single pulse");
    adc_cause_a: assert property (adc_start |-> $past(trig_ev[1] && adc_enable))
        else $error("Conversion start without unit two trigger");
    trig_adc_a: assert property ((trig_ev[1] && adc_enable) |=> adc_start)
        else $error("Unit two trigger did not start conversion");
    adc_two_a: assert property ((trig_ev[0] && !trig_ev[1]) |=> !adc_start)
        else $error("Unit one trigger started a conversion");
    trig_only_a: assert property (timer_one_reset |-> $past(|trig_ev))
        else $error("Timer one reset without a trigger");

    // Bus answers come from flops and stand one cycle
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("Ready held longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("Error answer without ready");
    rd_idle_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("Read data shown outside an answer");

    capture_c: cover property (cap_ev[0] ##1 flag_r[0]);
    trigger_c: cover property (trig_ev[1] && adc_enable ##1 adc_start);
    pwm_c: cover property (pwm_set[0] ##[1:300] pwm_clr[0]);
    clear_c: cover property (flag_clr[1] && cap_ev[1]);
    compare_c: cover property (cmp_ev[0] ##1 pin_out_r[0]);

endmodule : ccpu_unit

`default_nettype wire

// ===== sim/ccpu_timers.sv
// Stand-ins for timer one and timer two beside the capture/compare/PWM pair.
// Assumes the bench loads and starts timer one; both count on pclk.
`timescale 1ns/1ps
`default_nettype none
module ccpu_timers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic t1_run,
    input wire logic t1_load,
    input wire logic [15:0] t1_val,
    input wire logic timer_one_reset,
    input wire logic [7:0] timer_two_period,
    output logic [15:0] timer_one_count,
    output logic [7:0] timer_two_count,
    output logic [1:0] timer_two_frac,
    output logic timer_two_inc
);
    assign timer_two_inc = (timer_two_frac == 2'h3);
    // Synchronous counting only; an asynchronous counter is not supported
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_one_count <= 16'h0000;
        end else if (timer_one_reset) begin
            timer_one_count <= 16'h0000;
        end else if (t1_load) begin
            timer_one_count <= t1_val;
        end else if (t1_run) begin
            timer_one_count <= timer_one_count + 16'h0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_two_count <= 8'h00;
            timer_two_frac <= 2'h0;
        end else begin
            timer_two_frac <= timer_two_frac + 2'h1;
            if (timer_two_inc) begin
                timer_two_count <= (timer_two_count == timer_two_period) ? 8'h00
                    : timer_two_count + 8'h01;
            end
        end
    end
endmodule : ccpu_timers
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the capture/compare/PWM pair.
// Assumes ccpu_timers stands in for both timers; registers reached over APB.
`include "ccpu_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, adc_enable = 0;
    logic t1_run = 0, t1_load = 0, pready, pslverr, t1_rst, adc_st, t2_inc, err;
    logic [7:0] paddr = 8'h00, t2_per = 8'h03, t2c;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] pin = 2'h0, pout, flg, t2f;
    logic [15:0] t1_val = 16'h0000, t1c;
    int mismatches = 0, total_checks = 0;
    localparam logic [7:0] AL1 = {`CCPU_IDX_U1_LOW, 2'b00};
    localparam logic [7:0] AH1 = {`CCPU_IDX_U1_HIGH, 2'b00};
    localparam logic [7:0] AC1 = {`CCPU_IDX_U1_CTRL, 2'b00};
    localparam logic [7:0] AL2 = {`CCPU_IDX_U2_LOW, 2'b00};
    localparam logic [7:0] AC2 = {`CCPU_IDX_U2_CTRL, 2'b00};
    localparam logic [7:0] AFL = {`CCPU_IDX_FLAGS, 2'b00};
    always #4 pclk = ~pclk;
    ccpu_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unit_pin_in(pin), .timer_one_count(t1c), .timer_two_count(t2c),
        .timer_two_period(t2_per), .timer_two_frac(t2f), .timer_two_inc(t2_inc),
        .adc_enable(adc_enable), .unit_pin_out(pout), .unit_event_flag(flg),
        .timer_one_reset(t1_rst), .adc_start(adc_st));
    ccpu_timers tim_u (.pclk(pclk), .presetn(presetn), .t1_run(t1_run), .t1_load(t1_load),
        .t1_val(t1_val), .timer_one_reset(t1_rst), .timer_two_period(t2_per),
        .timer_one_count(t1c), .timer_two_count(t2c), .timer_two_frac(t2f),
        .timer_two_inc(t2_inc));
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            mismatches++;
            $display("Error at %0t: bus answer timed out", $time);
            results();
        end
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge pclk);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task automatic load(input logic [15:0] v, input logic run);
        @(posedge pclk);
        t1_val <= v;
        t1_load <= 1'b1;
        t1_run <= run;
        @(posedge pclk);
        t1_load <= 1'b0;
    endtask : load
    // Each level held at least seven cycles, well above the two-cycle minimum
    task automatic drive(input int b, input logic v);
        @(posedge pclk);
        pin[b] <= v;
        tick(6);
    endtask : drive
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (flg[b] !== 1'b1 && n < 200);
        if (flg[b] !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: event flag timed out", $time);
            results();
        end
    endtask : wait_flag
    task automatic t_regs;
        rchk(AC1, 32'h0);
        rchk(AC2, 32'h0);
        wr(AC2, 32'hFF);
        rchk(AC2, 32'h3F);
        apb(1'b0, 8'h00, 32'h0);
        chk(err, 1'b1);
        wr(AC2, 32'h0);
    endtask : t_regs
    task automatic t_capture;
        load(16'h1234, 1'b0);
        wr(AC1, 32'h05);
        drive(0, 1'b1);
        chk(flg[0], 1'b1);
        rchk(AL1, 32'h34);
        rchk(AH1, 32'h12);
        load(16'hABCD, 1'b0);
        drive(0, 1'b0);
        drive(0, 1'b1);
        rchk(AL1, 32'hCD);
        wr(AFL, 32'h1);
        chk(flg[0], 1'b0);
        wr(AC1, 32'h0);
        wr(AC1, 32'h06);
        wr(AFL, 32'h1);
        for (int i = 1; i <= 8; i++) begin
            drive(0, 1'b0);
            drive(0, 1'b1);
            chk(flg[0], (i % 4) == 0);
            if (i == 4) begin
                wr(AFL, 32'h1);
            end
        end
        wr(AC2, 32'h04);
        wr(AFL, 32'h2);
        drive(1, 1'b1);
        chk(flg[1], 1'b0);
        drive(1, 1'b0);
        chk(flg[1], 1'b1);
        rchk(AL2, 32'hCD);
        wr(AC1, 32'h0);
        wr(AC2, 32'h0);
    endtask : t_capture
    task automatic t_compare;
        logic [3:0] m[4] = '{4'h8, 4'hA, 4'h9, 4'h8};
        logic e[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        wr(AL1, 32'h10);
        wr(AH1, 32'h00);
        for (int i = 0; i < 4; i++) begin
            load(16'h0000, 1'b0);
            wr(AC1, {28'h0, m[i]});
            wr(AFL, 32'h3);
            load(16'h0000, 1'b1);
            wait_flag(0);
            chk(t1c, 32'h11);
            chk(pout[0], e[i]);
        end
        wr(AC1, 32'h0);
        // Latch clears at the edge after the write lands
        tick(1);
        chk(pout[0], 1'b0);
    endtask : t_compare
    // Trigger mode keeps both units on one cleared time base
    task automatic trig(input logic [7:0] ca, input logic [7:0] la, input int u, input logic ae);
        load(16'h0000, 1'b0);
        wr(la, 32'h20);
        wr(la + 8'h04, 32'h00);
        wr(ca, 32'h0B);
        wr(AFL, 32'h3);
        load(16'h0000, 1'b1);
        wait_flag(u);
        chk(t1_rst, 1'b1);
        chk(adc_st, ae);
        chk(t1c, 32'h21);
        @(posedge pclk);
        chk(t1_rst, 1'b0);
        chk(t1c, 32'h0);
        wr(ca, 32'h0);
    endtask : trig
    // Registered clear adds one cycle to the high time
    task automatic t_pwm;
        logic [7:0] c[4] = '{8'h0C, 8'h1C, 8'h0C, 8'h0C};
        logic [7:0] l[4] = '{8'h02, 8'h02, 8'h05, 8'h00};
        int e[4] = '{9, 10, 16, 0};
        int h;
        for (int i = 0; i < 4; i++) begin
            wr(AL1, {24'h0, l[i]});
            wr(AC1, {24'h0, c[i]});
            tick(40);
            h = 0;
            repeat (16) begin
                @(posedge pclk);
                h += (pout[0] === 1'b1);
            end
            chk(h, e[i]);
        end
        t2_per <= 8'hFF;
        wr(AL1, 32'h07);
        tick(1100);
        wr(AH1, 32'hFF);
        rchk(AH1, 32'h07);
    endtask : t_pwm
    initial begin
        tick(2);
        presetn <= 1'b1;
        adc_enable <= 1'b1;
        t_regs();
        t_capture();
        t_compare();
        trig(AC2, AL2, 1, 1'b1);
        trig(AC1, AL1, 0, 1'b0);
        t_pwm();
        results();
    end
endmodule : tb
`default_nettype wire
